// ---- arw_cfg.svh ----
`ifndef ARW_CFG_SVH
`define ARW_CFG_SVH
// register offsets (byte addresses on the plain port)
`define ARW_OFS_WINCTRL 8'h04
`define ARW_OFS_FLAGS 8'h0B
`define ARW_OFS_DBG 8'h0C
`define ARW_OFS_STAGE 8'h0D
`define ARW_OFS_RESULT 8'h10
`define ARW_OFS_LOW_THR 8'h12
`define ARW_OFS_HIGH_THR 8'h14
`define ARW_HI_STEP 8'h01
// field positions
`define ARW_BIT_DEBUG_RUN 0
`define ARW_BIT_READY 0
`define ARW_BIT_MATCH 1
`define ARW_FLD_WINSEL_LO 0
`define ARW_FLD_ACC_LO 4
// reset values
`define ARW_RST_BYTE 8'h00
`define ARW_RST_WORD 16'h0000
// code limits of one conversion, and the accumulation select cap
`define ARW_CODE_MAX 10'h3FF
`define ARW_CODE_MIN 10'h000
`define ARW_ACC_LOG2_MAX 3'h6
`endif

// ---- arw_pkg.sv ----
`default_nettype none
package arw_pkg;
  typedef logic [7:0] arw_byte_t;
  typedef logic [15:0] arw_word_t;
  // window condition encodings
  typedef enum logic [2:0] {
    ARW_WIN_NONE = 3'h0,
    ARW_WIN_BELOW = 3'h1,
    ARW_WIN_ABOVE = 3'h2,
    ARW_WIN_INSIDE = 3'h3,
    ARW_WIN_OUTSIDE = 3'h4
  } arw_win_e;
  // accumulation sequencer, one-hot
  typedef enum logic [1:0] {
    ARW_ST_WAIT = 2'h1,
    ARW_ST_SUM = 2'h2
  } arw_state_e;
endpackage
`default_nettype wire

// ---- arw_res_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface arw_calc_if #(parameter int RAW_W = 12);
  logic samp_valid;
  logic [RAW_W-1:0] samp_raw;
  logic [2:0] acc_log2;
  logic [2:0] win_mode;
  arw_pkg::arw_word_t thr_lo;
  arw_pkg::arw_word_t thr_hi;
  logic done;
  arw_pkg::arw_word_t result;
  logic match;
  modport regs (
    output samp_valid, samp_raw, acc_log2, win_mode, thr_lo, thr_hi,
    input done, result, match
  );
  modport calc (
    input samp_valid, samp_raw, acc_log2, win_mode, thr_lo, thr_hi,
    output done, result, match
  );
endinterface
`default_nettype wire

// ---- arw_calc.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "arw_cfg.svh"
module arw_calc #(
  parameter int RAW_W = 12
) (
  input wire logic ref_clk, // peripheral clock
  input wire logic reset, // synchronous, active high
  arw_calc_if.calc cbus // sample in, result out
);
  // elaboration guard: the sign bit must sit above the ten code bits
  if (RAW_W < 11) begin : g_raw_w_check
    $error("arw_calc: RAW_W must be at least 11");
  end

  logic samp_neg;
  logic samp_over;
  logic [9:0] samp_code;
  logic [15:0] sum_add;
  logic [6:0] acc_target;
  logic samp_last;
  logic win_hit;
  arw_pkg::arw_state_e state_reg;
  logic [15:0] sum_reg;
  logic [6:0] cnt_reg;
  logic done_reg;
  logic match_reg;
  arw_pkg::arw_word_t result_reg;

  // raw value is signed; clamp to the ten-bit code range
  assign samp_neg = cbus.samp_raw[RAW_W-1];
  assign samp_over = !samp_neg &&
    (cbus.samp_raw[RAW_W-2:0] > (RAW_W-1)'(`ARW_CODE_MAX));
  assign samp_code = samp_neg ? `ARW_CODE_MIN :
    samp_over ? `ARW_CODE_MAX : cbus.samp_raw[9:0];
  // 64 x 0x3FF = 0xFFC0, so sixteen bits never wrap
  assign sum_add = (state_reg == arw_pkg::ARW_ST_SUM ? sum_reg : 16'h0000)
    + {6'h00, samp_code};
  assign acc_target = 7'h01 << cbus.acc_log2;
  assign samp_last = (cnt_reg + 7'h01) == acc_target;
  // only the final sum is judged, never a partial sum
  assign win_hit =
    (cbus.win_mode == arw_pkg::ARW_WIN_BELOW) ? (sum_add < cbus.thr_lo) :
    (cbus.win_mode == arw_pkg::ARW_WIN_ABOVE) ? (sum_add > cbus.thr_hi) :
    (cbus.win_mode == arw_pkg::ARW_WIN_INSIDE) ?
      (sum_add > cbus.thr_lo && sum_add < cbus.thr_hi) :
    (cbus.win_mode == arw_pkg::ARW_WIN_OUTSIDE) ?
      (sum_add < cbus.thr_lo || sum_add > cbus.thr_hi) : 1'b0;

  // sequencer: count samples until the selected total is reached
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg <= arw_pkg::ARW_ST_WAIT;
      sum_reg <= `ARW_RST_WORD;
      cnt_reg <= 7'h00;
      done_reg <= 1'b0;
      match_reg <= 1'b0;
      result_reg <= `ARW_RST_WORD;
    end else begin
      done_reg <= 1'b0;
      if (cbus.samp_valid) begin
        case (state_reg)
          arw_pkg::ARW_ST_WAIT, arw_pkg::ARW_ST_SUM: begin
            if (samp_last) begin
              state_reg <= arw_pkg::ARW_ST_WAIT;
              cnt_reg <= 7'h00;
              result_reg <= sum_add;
              done_reg <= 1'b1;
              match_reg <= win_hit;
            end else begin
              state_reg <= arw_pkg::ARW_ST_SUM;
              cnt_reg <= cnt_reg + 7'h01;
              sum_reg <= sum_add;
            end
          end
          default: begin
            state_reg <= arw_pkg::ARW_ST_WAIT;
          end
        endcase
      end
    end
  end

  assign cbus.done = done_reg;
  assign cbus.result = result_reg;
  assign cbus.match = match_reg;
endmodule
`default_nettype wire

// ---- arw_regs.sv ----
// Local design decision: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "arw_cfg.svh"
module arw_regs #(
  parameter int RAW_W = 12
) (
  input wire logic ref_clk, // peripheral clock, 10 MHz
  input wire logic reset, // synchronous, active high
  input wire logic [7:0] bus_addr, // register byte address
  input wire logic [7:0] bus_wdata, // write data
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  output logic [7:0] bus_rdata, // read data, cycle after strobe
  input wire logic cpu_halted, // CPU held in break debug
  input wire logic samp_valid, // one conversion sample event
  input wire logic [RAW_W-1:0] samp_raw, // signed raw sample
  output logic conv_halted, // converter held by debug halt
  output logic result_ready_flag, // new result present
  output logic window_match_flag // result met window condition
);
  // elaboration guard: sign bit above ten code bits, sum fits a word
  if (RAW_W < 11 || RAW_W > 16) begin : g_raw_w_check
    $error("arw_regs: RAW_W must be 11 to 16");
  end

  arw_calc_if #(.RAW_W(RAW_W)) calc_bus ();

  arw_calc #(.RAW_W(RAW_W)) u_calc (
    .ref_clk(ref_clk),
    .reset(reset),
    .cbus(calc_bus)
  );

  logic [7:0] rdata_reg;
  logic halted_reg;
  logic ready_reg;
  logic match_reg;
  logic debug_run_enable_reg;
  logic [7:0] stage_reg;
  logic [7:0] stage_next;
  logic [2:0] winsel_reg;
  logic [2:0] acclog_reg;
  arw_pkg::arw_word_t window_low_threshold_reg;
  arw_pkg::arw_word_t window_high_threshold_reg;

  // address decode
  logic hit_winctrl;
  logic hit_flags;
  logic hit_dbg;
  logic hit_stage;
  logic hit_rslt_lo;
  logic hit_rslt_hi;
  logic hit_lt_lo;
  logic hit_lt_hi;
  logic hit_ht_lo;
  logic hit_ht_hi;
  assign hit_winctrl = bus_addr == `ARW_OFS_WINCTRL;
  assign hit_flags = bus_addr == `ARW_OFS_FLAGS;
  assign hit_dbg = bus_addr == `ARW_OFS_DBG;
  assign hit_stage = bus_addr == `ARW_OFS_STAGE;
  assign hit_rslt_lo = bus_addr == `ARW_OFS_RESULT;
  assign hit_rslt_hi = bus_addr == (`ARW_OFS_RESULT + `ARW_HI_STEP);
  assign hit_lt_lo = bus_addr == `ARW_OFS_LOW_THR;
  assign hit_lt_hi = bus_addr == (`ARW_OFS_LOW_THR + `ARW_HI_STEP);
  assign hit_ht_lo = bus_addr == `ARW_OFS_HIGH_THR;
  assign hit_ht_hi = bus_addr == (`ARW_OFS_HIGH_THR + `ARW_HI_STEP);

  // strobe qualified selects
  logic wr_winctrl;
  logic wr_flags;
  logic wr_dbg;
  logic wr_stage;
  logic wr_lo16;
  logic wr_lt_hi;
  logic wr_ht_hi;
  logic rd_lo16;
  logic rd_rslt_lo;
  assign wr_winctrl = bus_wr && hit_winctrl;
  assign wr_flags = bus_wr && hit_flags;
  assign wr_dbg = bus_wr && hit_dbg;
  assign wr_stage = bus_wr && hit_stage;
  assign wr_lo16 = bus_wr && (hit_lt_lo || hit_ht_lo);
  assign wr_lt_hi = bus_wr && hit_lt_hi;
  assign wr_ht_hi = bus_wr && hit_ht_hi;
  assign rd_rslt_lo = bus_rd && hit_rslt_lo;
  assign rd_lo16 = bus_rd && (hit_rslt_lo || hit_lt_lo || hit_ht_lo);

  // converter is frozen only when the CPU halts without debug run
  logic halt_now;
  assign halt_now = cpu_halted && !debug_run_enable_reg;

  // samples are dropped while frozen so no event sneaks in
  assign calc_bus.samp_valid = samp_valid && !halt_now;
  assign calc_bus.samp_raw = samp_raw;
  assign calc_bus.acc_log2 = acclog_reg;
  assign calc_bus.win_mode = winsel_reg;
  assign calc_bus.thr_lo = window_low_threshold_reg;
  assign calc_bus.thr_hi = window_high_threshold_reg;

  // high byte that a low-byte read parks in staging
  logic [7:0] hi_of_lo;
  assign hi_of_lo = hit_rslt_lo ? calc_bus.result[15:8] :
    hit_lt_lo ? window_low_threshold_reg[15:8] : window_high_threshold_reg[15:8];

  // staging: direct write, low-byte write, or low-byte read
  // a high-byte read returns staging so both halves match
  assign stage_next = wr_stage ? bus_wdata :
    wr_lo16 ? bus_wdata :
    rd_lo16 ? hi_of_lo : stage_reg;

  // high-byte reads come from staging, not the live register
  logic [7:0] rd_mux;
  assign rd_mux =
    hit_winctrl ? {1'b0, acclog_reg, 1'b0, winsel_reg} :
    hit_flags ? {6'h00, match_reg, ready_reg} :
    hit_dbg ? {7'h00, debug_run_enable_reg} :
    hit_stage ? stage_reg :
    hit_rslt_lo ? calc_bus.result[7:0] :
    hit_lt_lo ? window_low_threshold_reg[7:0] :
    hit_ht_lo ? window_high_threshold_reg[7:0] :
    (hit_rslt_hi || hit_lt_hi || hit_ht_hi) ? stage_reg :
    8'h00;

  // flag update: a set in the clearing cycle wins
  logic clr_ready;
  logic clr_match;
  logic ready_next;
  logic match_next;
  assign clr_ready = rd_rslt_lo ||
    (wr_flags && bus_wdata[`ARW_BIT_READY]);
  assign clr_match = rd_rslt_lo ||
    (wr_flags && bus_wdata[`ARW_BIT_MATCH]);
  assign ready_next = calc_bus.done ? 1'b1 :
    clr_ready ? 1'b0 : ready_reg;
  assign match_next = (calc_bus.done && calc_bus.match) ? 1'b1 :
    clr_match ? 1'b0 : match_reg;

  // accumulation select above six would pass 128 samples
  logic [2:0] acclog_wr;
  assign acclog_wr = (bus_wdata[`ARW_FLD_ACC_LO +: 3] > `ARW_ACC_LOG2_MAX) ?
    `ARW_ACC_LOG2_MAX : bus_wdata[`ARW_FLD_ACC_LO +: 3];

  // control registers
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      debug_run_enable_reg <= 1'b0;
      winsel_reg <= 3'h0;
      acclog_reg <= 3'h0;
    end else begin
      if (wr_dbg) begin
        debug_run_enable_reg <= bus_wdata[`ARW_BIT_DEBUG_RUN];
      end
      if (wr_winctrl) begin
        winsel_reg <= bus_wdata[`ARW_FLD_WINSEL_LO +: 3];
        acclog_reg <= acclog_wr;
      end
    end
  end

  // staging register
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      stage_reg <= `ARW_RST_BYTE;
    end else begin
      stage_reg <= stage_next;
    end
  end

  // thresholds commit whole on the high-byte write
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      window_low_threshold_reg <= `ARW_RST_WORD;
      window_high_threshold_reg <= `ARW_RST_WORD;
    end else begin
      if (wr_lt_hi) begin
        window_low_threshold_reg <= {bus_wdata, stage_reg};
      end
      if (wr_ht_hi) begin
        window_high_threshold_reg <= {bus_wdata, stage_reg};
      end
    end
  end

  // flags and status outputs
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ready_reg <= 1'b0;
      match_reg <= 1'b0;
      halted_reg <= 1'b0;
    end else begin
      ready_reg <= ready_next;
      match_reg <= match_next;
      halted_reg <= halt_now;
    end
  end

  // read data live only in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= bus_rd ? rd_mux : 8'h00;
    end
  end

  assign bus_rdata = rdata_reg;
  assign conv_halted = halted_reg;
  assign result_ready_flag = ready_reg;
  assign window_match_flag = match_reg;
endmodule
`default_nettype wire

// ---- arw_regs_assertions.sv ----
`timescale 1ns/10ps
`default_nettype none
module arw_regs_chk #(
  parameter int RAW_W = 12
) (
  input wire logic ref_clk, // clock
  input wire logic reset, // sync reset
  input wire logic [7:0] bus_addr, // address
  input wire logic [7:0] bus_wdata, // write data
  input wire logic bus_wr, // write strobe
  input wire logic bus_rd, // read strobe
  input wire logic [7:0] bus_rdata, // read data
  input wire logic cpu_halted, // cpu in break
  input wire logic samp_valid, // sample event
  input wire logic [RAW_W-1:0] samp_raw, // raw sample
  input wire logic conv_halted, // converter held
  input wire logic result_ready_flag, // ready flag
  input wire logic window_match_flag // match flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  // a set from a sample one edge back wins over any clear
  sequence s_result_read;
    bus_rd && bus_addr == 8'h10 && !$past(samp_valid);
  endsequence
  sequence s_flag_w1c;
    bus_wr && bus_addr == 8'h0B && bus_wdata[1:0] == 2'h3 && !$past(samp_valid);
  endsequence
  property p_rdata_idle;
    !$past(bus_rd) |-> bus_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
  property p_unmapped;
    bus_rd && bus_addr == 8'h20 |=> bus_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_halt_cause;
    conv_halted |-> $past(cpu_halted);
  endproperty
  a_halt_cause: assert property (p_halt_cause) else $error("halt without cpu halt");
  property p_ready_cause;
    $rose(result_ready_flag) |-> $past(samp_valid, 2);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("ready without sample");
  property p_sticky;
    result_ready_flag && !bus_rd && !bus_wr |=> result_ready_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("ready flag dropped alone");
  property p_rd_clear;
    s_result_read |=> !result_ready_flag && !window_match_flag;
  endproperty
  a_rd_clear: assert property (p_rd_clear) else $error("result read kept flags");
  property p_w1c;
    s_flag_w1c |=> !result_ready_flag && !window_match_flag;
  endproperty
  a_w1c: assert property (p_w1c) else $error("write one kept flags");
  property p_match_ready;
    $rose(window_match_flag) |-> result_ready_flag;
  endproperty
  a_match_ready: assert property (p_match_ready) else $error("match without result");
endmodule
`default_nettype wire

// ---- tb_adc_result_window_regs.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_adc_result_window_regs;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [7:0] bus_rdata;
  logic cpu_halted = 1'b0;
  logic samp_valid = 1'b0;
  logic [11:0] samp_raw = 12'h000;
  logic conv_halted;
  logic result_ready_flag;
  logic window_match_flag;
  int error_cnt = 0;
  int checked = 0;
  logic [7:0] rst_tab [11] = '{8'h04, 8'h0B, 8'h0C, 8'h0D, 8'h10, 8'h11, 8'h12, 8'h13,
    8'h14, 8'h15, 8'h20};
  logic [11:0] raw_tab [3] = '{12'h800, 12'h7FF, 12'h155};
  logic [15:0] rslt_tab [3] = '{16'h0000, 16'h03FF, 16'h0155};
  logic [15:0] val_tab [3] = '{16'h0080, 16'h0180, 16'h0280};
  // clock at 10 MHz
  always #50 ref_clk = ~ref_clk;
  arw_regs #(.RAW_W(12)) dut (
    .ref_clk(ref_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_halted(cpu_halted),
    .samp_valid(samp_valid), .samp_raw(samp_raw), .conv_halted(conv_halted),
    .result_ready_flag(result_ready_flag), .window_match_flag(window_match_flag)
  );
  task automatic chk(input string name, input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one-cycle strobes; the next call lets an edge pass before raising again
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge ref_clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge ref_clk);
    bus_rd <= 1'b0;
    #1;
    chk($sformatf("reg_%h", a), {8'h00, bus_rdata}, {8'h00, exp});
  endtask
  // one sample, then room for the flags to land
  task automatic samp(input logic [11:0] v);
    @(posedge ref_clk);
    samp_valid <= 1'b1;
    samp_raw <= v;
    @(posedge ref_clk);
    samp_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  function automatic logic win_exp(input int m, input logic [15:0] v);
    case (m)
      1: return v < 16'h0100;
      2: return v > 16'h0200;
      3: return v > 16'h0100 && v < 16'h0200;
      4: return v < 16'h0100 || v > 16'h0200;
      default: return 1'b0;
    endcase
  endfunction
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #(100 * 20000);
    error_cnt++;
    $display("ERROR watchdog expected end seen timeout");
    tally_and_finish();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    foreach (rst_tab[i]) rd(rst_tab[i], 8'h00);
    $display("test reset values done");
    wr(8'h12, 8'h34);
    wr(8'h13, 8'h12);
    rd(8'h12, 8'h34);
    rd(8'h13, 8'h12);
    rd(8'h0D, 8'h12);
    wr(8'h0D, 8'h5A);
    rd(8'h0D, 8'h5A);
    rd(8'h13, 8'h5A);
    wr(8'h14, 8'hCD);
    rd(8'h0D, 8'hCD);
    wr(8'h15, 8'hAB);
    rd(8'h14, 8'hCD);
    rd(8'h15, 8'hAB);
    $display("test staging done");
    for (int i = 0; i < 3; i++) begin
      samp(raw_tab[i]);
      chk("ready", result_ready_flag, 1'b1);
      rd(8'h10, rslt_tab[i][7:0]);
      rd(8'h11, rslt_tab[i][15:8]);
      chk("flags", {result_ready_flag, window_match_flag}, 2'h0);
    end
    wr(8'h10, 8'hAA);
    wr(8'h11, 8'h66);
    rd(8'h10, 8'h55);
    rd(8'h11, 8'h01);
    $display("test clamp done");
    wr(8'h12, 8'h00);
    wr(8'h13, 8'h01);
    wr(8'h14, 8'h00);
    wr(8'h15, 8'h02);
    for (int m = 0; m < 6; m++) begin
      for (int i = 0; i < 3; i++) begin
        wr(8'h04, 8'(m));
        samp(val_tab[i][11:0]);
        chk("match", window_match_flag, win_exp(m, val_tab[i]));
        wr(8'h0B, 8'h00);
        chk("ready", result_ready_flag, 1'b1);
        wr(8'h0B, 8'h03);
        chk("flags", {result_ready_flag, window_match_flag}, 2'h0);
      end
    end
    $display("test window done");
    wr(8'h04, 8'h72);
    rd(8'h04, 8'h62);
    @(posedge ref_clk);
    samp_valid <= 1'b1;
    samp_raw <= 12'h7FF;
    repeat (63) @(posedge ref_clk);
    samp_valid <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("flags", {result_ready_flag, window_match_flag}, 2'h0);
    samp(12'h7FF);
    chk("flags", {result_ready_flag, window_match_flag}, 2'h3);
    rd(8'h0B, 8'h03);
    rd(8'h10, 8'hC0);
    rd(8'h11, 8'hFF);
    $display("test accumulate done");
    wr(8'h04, 8'h00);
    cpu_halted <= 1'b1;
    samp(12'h123);
    chk("halt", conv_halted, 1'b1);
    chk("ready", result_ready_flag, 1'b0);
    wr(8'h0C, 8'h01);
    samp(12'h123);
    chk("halt", conv_halted, 1'b0);
    chk("ready", result_ready_flag, 1'b1);
    rd(8'h10, 8'h23);
    rd(8'h0C, 8'h01);
    cpu_halted <= 1'b0;
    $display("test debug run done");
    tally_and_finish();
  end
endmodule
bind arw_regs arw_regs_chk #(.RAW_W(RAW_W)) u_chk (
  .ref_clk(ref_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .cpu_halted(cpu_halted),
  .samp_valid(samp_valid), .samp_raw(samp_raw), .conv_halted(conv_halted),
  .result_ready_flag(result_ready_flag), .window_match_flag(window_match_flag)
);
`default_nettype wire
